// *** logic/bmg_cfg.svh ***
`ifndef BMG_CFG_SVH
`define BMG_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BMG_OFS_LOW_DIR    8'h10
`define BMG_OFS_LOW_DAT    8'h11
`define BMG_OFS_HIGH_DIR   8'h12
`define BMG_OFS_HIGH_DAT   8'h13
`define BMG_OFS_CTRL_DIR   8'h14
`define BMG_OFS_CTRL_DAT   8'h15
`define BMG_OFS_MODE       8'h16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BMG_DIR_RST        8'hFF
`define BMG_CTRL_DIR_RST   4'hF
`define BMG_LATCH_POR      8'h00
`define BMG_CTRL_LATCH_POR 4'h0
`define BMG_BYTE_ZERO      8'h00
`define BMG_WORD_ZERO      16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BMG_BIT_ALE        0
`define BMG_BIT_OE         1
`define BMG_BIT_WR         2
`define BMG_BIT_CAP        3
`define BMG_CTRL_MSB       3
`define BMG_MODE_MSB       1
`define BMG_AD_LO_MSB      7
`define BMG_AD_HI_LSB      8
`define BMG_AD_HI_MSB      15
`define BMG_CTRL_BUS_PINS  4'h7

`endif

// *** logic/bmg_pkg.sv ***
package bmg_pkg;

   // Device operating modes; the two middle ones hand the ports to the bus
   typedef enum logic [1:0] {
      BMG_MODE_MCU,
      BMG_MODE_EXT,
      BMG_MODE_MPU,
      BMG_MODE_PROT
   } bmg_mode_t;

   typedef struct packed {
      logic [7:0]  low_dir;
      logic [7:0]  low_dat;
      logic [7:0]  high_dir;
      logic [7:0]  high_dat;
      logic [3:0]  ctrl_dir;
      logic [3:0]  ctrl_dat;
      bmg_mode_t   mode;
      logic [7:0]  rdata;
      logic [15:0] ad_in;
      logic        cap_in;
   } bmg_state_t;

endpackage : bmg_pkg

// *** logic/bmg_pin_cell.sv ***
`timescale 1ns/1ps

// Per-pin output mux: the alternate function, when enabled, owns both the
// level and the enable; otherwise the latch drives and the direction bit
// gates it (1 = input, so the active-low enable is simply the bit).
module bmg_pin_cell #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] gpio_dat,
   input  wire logic [WIDTH-1:0] gpio_dir,
   input  wire logic [WIDTH-1:0] alt_en,
   input  wire logic [WIDTH-1:0] alt_out,
   input  wire logic [WIDTH-1:0] alt_oe_n,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe_n
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         assign pin_out[i]  = alt_en[i] ? alt_out[i]  : gpio_dat[i];
         assign pin_oe_n[i] = alt_en[i] ? alt_oe_n[i] : gpio_dir[i];
      end
   endgenerate

endmodule // bmg_pin_cell

// *** logic/bmg_ports.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "bmg_cfg.svh"

module bmg_ports (
   input  wire logic        SYS_CLK,
   input  wire logic        SRST,
   input  wire logic        WARM_RST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [7:0]  WR_DATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   output logic      [7:0]  RD_DATA,
   input  wire logic [7:0]  LOW_PIN_IN,
   output logic      [7:0]  LOW_PIN_OUT,
   output logic      [7:0]  LOW_PIN_OE_N,
   input  wire logic [7:0]  HIGH_PIN_IN,
   output logic      [7:0]  HIGH_PIN_OUT,
   output logic      [7:0]  HIGH_PIN_OE_N,
   input  wire logic [3:0]  CTRL_PIN_IN,
   output logic      [3:0]  CTRL_PIN_OUT,
   output logic      [3:0]  CTRL_PIN_OE_N,
   input  wire logic [15:0] BUS_AD_OUT,
   input  wire logic        BUS_AD_DRIVE,
   input  wire logic        BUS_ALE,
   input  wire logic        BUS_OE_N,
   input  wire logic        BUS_WR_N,
   output logic      [15:0] BUS_AD_IN,
   output logic             BUS_MODE,
   output logic             FOURTH_CAPTURE_INPUT
);

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic bus_sel(input bmg_pkg::bmg_mode_t m);
      bus_sel = (m == bmg_pkg::BMG_MODE_EXT) || (m == bmg_pkg::BMG_MODE_MPU);
   endfunction

   // Power-on latch value is a defined zero rather than unknown
   localparam bmg_pkg::bmg_state_t RST_ST = '{
      low_dir  : `BMG_DIR_RST,
      low_dat  : `BMG_LATCH_POR,
      high_dir : `BMG_DIR_RST,
      high_dat : `BMG_LATCH_POR,
      ctrl_dir : `BMG_CTRL_DIR_RST,
      ctrl_dat : `BMG_CTRL_LATCH_POR,
      mode     : bmg_pkg::BMG_MODE_MCU,
      rdata    : `BMG_BYTE_ZERO,
      ad_in    : `BMG_WORD_ZERO,
      cap_in   : 1'b0
   };

   bmg_pkg::bmg_state_t st_r;
   bmg_pkg::bmg_state_t st_nxt;
   logic                bus_on;
   logic [3:0]          ctrl_alt_en;
   logic [3:0]          ctrl_alt_out;
   logic [7:0]          ad_oe_n;

   assign bus_on = bus_sel(st_r.mode);

   // ----------------------------------------
   // Register file and sampled inputs
   // ----------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.ad_in  = {HIGH_PIN_IN, LOW_PIN_IN};
      st_nxt.cap_in = CTRL_PIN_IN[`BMG_BIT_CAP];
      st_nxt.rdata  = `BMG_BYTE_ZERO;
      if (WR_STB) begin
         case (ADDR)
            `BMG_OFS_LOW_DIR:  st_nxt.low_dir  = WR_DATA;
            `BMG_OFS_LOW_DAT:  st_nxt.low_dat  = WR_DATA;
            `BMG_OFS_HIGH_DIR: st_nxt.high_dir = WR_DATA;
            `BMG_OFS_HIGH_DAT: st_nxt.high_dat = WR_DATA;
            `BMG_OFS_CTRL_DIR: st_nxt.ctrl_dir = WR_DATA[`BMG_CTRL_MSB:0];
            `BMG_OFS_CTRL_DAT: st_nxt.ctrl_dat = WR_DATA[`BMG_CTRL_MSB:0];
            `BMG_OFS_MODE:     st_nxt.mode     = bmg_pkg::bmg_mode_t'(WR_DATA[`BMG_MODE_MSB:0]);
            default:           st_nxt.mode     = st_r.mode;
         endcase
      end
      if (RD_STB) begin
         case (ADDR)
            `BMG_OFS_LOW_DIR:  st_nxt.rdata = st_r.low_dir;
            `BMG_OFS_LOW_DAT:  st_nxt.rdata = LOW_PIN_IN;
            `BMG_OFS_HIGH_DIR: st_nxt.rdata = st_r.high_dir;
            `BMG_OFS_HIGH_DAT: st_nxt.rdata = HIGH_PIN_IN;
            `BMG_OFS_CTRL_DIR: st_nxt.rdata = {4'h0, st_r.ctrl_dir};
            `BMG_OFS_CTRL_DAT: st_nxt.rdata = {4'h0, CTRL_PIN_IN};
            `BMG_OFS_MODE:     st_nxt.rdata = {6'h00, st_r.mode};
            default:           st_nxt.rdata = `BMG_BYTE_ZERO;
         endcase
      end
      // Warm reset forces inputs but leaves latches and mode untouched
      if (WARM_RST) begin
         st_nxt.low_dir  = `BMG_DIR_RST;
         st_nxt.high_dir = `BMG_DIR_RST;
         st_nxt.ctrl_dir = `BMG_CTRL_DIR_RST;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         st_r <= RST_ST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Pin multiplexing
   // ----------------------------------------
   // The bus engine decides when address/data pins drive; in bus mode the strobes always drive
   assign ad_oe_n = {8{~BUS_AD_DRIVE}};

   always_comb begin
      ctrl_alt_en                  = bus_on ? `BMG_CTRL_BUS_PINS : 4'h0;
      ctrl_alt_out                 = 4'h0;
      ctrl_alt_out[`BMG_BIT_ALE]   = BUS_ALE;
      ctrl_alt_out[`BMG_BIT_OE]    = BUS_OE_N;
      ctrl_alt_out[`BMG_BIT_WR]    = BUS_WR_N;
   end

   bmg_pin_cell #(.WIDTH(8)) u_low (
      .gpio_dat (st_r.low_dat),
      .gpio_dir (st_r.low_dir),
      .alt_en   ({8{bus_on}}),
      .alt_out  (BUS_AD_OUT[`BMG_AD_LO_MSB:0]),
      .alt_oe_n (ad_oe_n),
      .pin_out  (LOW_PIN_OUT),
      .pin_oe_n (LOW_PIN_OE_N)
   );

   bmg_pin_cell #(.WIDTH(8)) u_high (
      .gpio_dat (st_r.high_dat),
      .gpio_dir (st_r.high_dir),
      .alt_en   ({8{bus_on}}),
      .alt_out  (BUS_AD_OUT[`BMG_AD_HI_MSB:`BMG_AD_HI_LSB]),
      .alt_oe_n (ad_oe_n),
      .pin_out  (HIGH_PIN_OUT),
      .pin_oe_n (HIGH_PIN_OE_N)
   );

   bmg_pin_cell #(.WIDTH(4)) u_ctrl (
      .gpio_dat (st_r.ctrl_dat),
      .gpio_dir (st_r.ctrl_dir),
      .alt_en   (ctrl_alt_en),
      .alt_out  (ctrl_alt_out),
      .alt_oe_n (4'h0),
      .pin_out  (CTRL_PIN_OUT),
      .pin_oe_n (CTRL_PIN_OE_N)
   );

   assign RD_DATA              = st_r.rdata;
   assign BUS_AD_IN            = st_r.ad_in;
   assign BUS_MODE             = bus_on;
   assign FOURTH_CAPTURE_INPUT = st_r.cap_in;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   high_dir_gpio_a: assert property (
      !bus_on |-> (HIGH_PIN_OE_N == st_r.high_dir && HIGH_PIN_OUT == st_r.high_dat))
      else $error("High port enable does not follow its direction register");

   pin_readback_a: assert property (
      (RD_STB && ADDR == `BMG_OFS_HIGH_DAT) |=> (RD_DATA == $past(HIGH_PIN_IN)))
      else $error("High data read did not return pin levels");

   latch_write_a: assert property (
      (WR_STB && ADDR == `BMG_OFS_LOW_DAT && !WARM_RST && !bus_on)
      |=> (LOW_PIN_OUT == $past(WR_DATA) && $stable(LOW_PIN_OE_N)))
      else $error("Low data write did not reach the latch alone");

   bus_upper_a: assert property (
      bus_on |-> (HIGH_PIN_OUT == BUS_AD_OUT[`BMG_AD_HI_MSB:`BMG_AD_HI_LSB]
                  && HIGH_PIN_OE_N == {8{~BUS_AD_DRIVE}}))
      else $error("High port does not carry upper bus byte");

   mode_switch_a: assert property (
      (WR_STB && ADDR == `BMG_OFS_MODE)
      |=> (BUS_MODE == ($past(WR_DATA[`BMG_MODE_MSB:0]) == 2'h1 || $past(WR_DATA[`BMG_MODE_MSB:0]) == 2'h2)))
      else $error("Bus mode does not follow the written mode");

   ctrl_bus_pins_a: assert property (
      bus_on |-> (CTRL_PIN_OE_N[2:0] == 3'h0 && CTRL_PIN_OE_N[3] == st_r.ctrl_dir[3]
                  && CTRL_PIN_OUT[3] == st_r.ctrl_dat[3]))
      else $error("Control port ownership wrong in bus mode");

   strobe_map_a: assert property (
      bus_on |-> (CTRL_PIN_OUT[0] == BUS_ALE && CTRL_PIN_OUT[1] == BUS_OE_N && CTRL_PIN_OUT[2] == BUS_WR_N))
      else $error("Bus strobes misplaced or inverted");

   ctrl_gpio_a: assert property (
      !bus_on |-> (CTRL_PIN_OE_N == st_r.ctrl_dir && CTRL_PIN_OUT == st_r.ctrl_dat))
      else $error("Control port not plain GPIO outside bus mode");

   bus_lower_a: assert property (
      bus_on |-> (LOW_PIN_OUT == BUS_AD_OUT[`BMG_AD_LO_MSB:0]))
      else $error("Low port does not carry lower bus byte");

   // A data write in the same cycle as warm reset still lands, so skip that case
   warm_reset_a: assert property (
      (WARM_RST && !(WR_STB && ADDR == `BMG_OFS_HIGH_DAT))
      |=> (HIGH_PIN_OE_N == 8'hFF || bus_on) && st_r.low_dir == 8'hFF
                   && st_r.high_dat == $past(st_r.high_dat))
      else $error("Warm reset did not force inputs or lost a latch");

   ctrl_upper_zero_a: assert property (
      (RD_STB && (ADDR == `BMG_OFS_CTRL_DIR || ADDR == `BMG_OFS_CTRL_DAT)) |=> (RD_DATA[7:4] == 4'h0))
      else $error("Unused control bits read nonzero");

   capture_path_a: assert property (
      !SRST |=> (FOURTH_CAPTURE_INPUT == $past(CTRL_PIN_IN[3])))
      else $error("Capture input does not follow control bit three");

endmodule // bmg_ports

// *** tb/bmg_far_side.sv ***
`timescale 1ns/1ps

// -----------------------------------------
// Pins and external memory
// -----------------------------------------
// A bit that the port releases shows what the far side drives there. The
// bench hands a fresh pattern every step, so a released line never keeps
// the port's last level.
module bmg_far_side (
   input  wire logic [7:0]  lo_out,
   input  wire logic [7:0]  lo_oe_n,
   input  wire logic [7:0]  hi_out,
   input  wire logic [7:0]  hi_oe_n,
   input  wire logic [3:0]  c_out,
   input  wire logic [3:0]  c_oe_n,
   input  wire logic [15:0] ext,
   input  wire logic [3:0]  c_ext,
   output logic      [7:0]  lo_lvl,
   output logic      [7:0]  hi_lvl,
   output logic      [3:0]  c_lvl
);
   assign lo_lvl = (lo_out & ~lo_oe_n) | (ext[7:0] & lo_oe_n);
   assign hi_lvl = (hi_out & ~hi_oe_n) | (ext[15:8] & hi_oe_n);
   assign c_lvl  = (c_out & ~c_oe_n) | (c_ext & c_oe_n);
endmodule // bmg_far_side

// *** tb/bmg_ports_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t mismatch %h %h", $time, (a), (b)); end end

module bmg_ports_tb;
   logic        sys_clk = 0, srst = 1, warm = 0, wr_stb = 0, rd_stb = 0;
   logic [7:0]  addr = 0, wr_data = 0, rd_data, d, v;
   logic [7:0]  lo_i, lo_o, lo_n, hi_i, hi_o, hi_n;
   logic [3:0]  c_i, c_o, c_n, c_ext = 0, ce;
   logic [15:0] ad_out = 0, ad_in, ext = 0;
   logic        drive = 0, ale = 0, oe_n = 1, wr_n = 1, bus_mode, cap, bus = 0;
   logic [7:0]  m [0:6] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h00};
   int          fail_count = 0, compares = 0, seed = 32'ha49a;

   always #25 sys_clk = ~sys_clk;

   bmg_ports bmg_ports_i (.SYS_CLK(sys_clk), .SRST(srst), .WARM_RST(warm), .ADDR(addr),
      .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
      .LOW_PIN_IN(lo_i), .LOW_PIN_OUT(lo_o), .LOW_PIN_OE_N(lo_n), .HIGH_PIN_IN(hi_i),
      .HIGH_PIN_OUT(hi_o), .HIGH_PIN_OE_N(hi_n), .CTRL_PIN_IN(c_i), .CTRL_PIN_OUT(c_o),
      .CTRL_PIN_OE_N(c_n), .BUS_AD_OUT(ad_out), .BUS_AD_DRIVE(drive), .BUS_ALE(ale),
      .BUS_OE_N(oe_n), .BUS_WR_N(wr_n), .BUS_AD_IN(ad_in), .BUS_MODE(bus_mode),
      .FOURTH_CAPTURE_INPUT(cap));

   bmg_far_side bmg_far_side_i (.lo_out(lo_o), .lo_oe_n(lo_n), .hi_out(hi_o), .hi_oe_n(hi_n),
      .c_out(c_o), .c_oe_n(c_n), .ext(ext), .c_ext(c_ext), .lo_lvl(lo_i), .hi_lvl(hi_i),
      .c_lvl(c_i));

   // -----------------------------------------
   // Reference model of pin levels
   // -----------------------------------------
   function automatic logic [7:0] lvl(logic [7:0] o, logic [7:0] n, logic [7:0] e);
      return (o & ~n) | (e & n);
   endfunction

   function automatic logic [7:0] e_lo();
      return bus ? lvl(ad_out[7:0], {8{~drive}}, ext[7:0]) : lvl(m[1], m[0], ext[7:0]);
   endfunction

   function automatic logic [7:0] e_hi();
      return bus ? lvl(ad_out[15:8], {8{~drive}}, ext[15:8]) : lvl(m[3], m[2], ext[15:8]);
   endfunction

   function automatic logic [3:0] e_c();
      logic [3:0] g;
      g = 4'(lvl({4'h0, m[5][3:0]}, {4'h0, m[4][3:0]}, {4'h0, c_ext}));
      return bus ? {g[3], wr_n, oe_n, ale} : g;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= dv;
      wr_stb <= 1;
      @(posedge sys_clk);
      wr_stb <= 0;
      if (a >= 8'h10 && a <= 8'h16) m[a - 8'h10] = (a == 8'h14 || a == 8'h15) ? {4'h0, dv[3:0]} : dv;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] dv);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1;
      @(posedge sys_clk);
      rd_stb <= 0;
      #1 dv = rd_data;
   endtask

   task automatic rd_all();
      for (int a = 0; a < 6; a++) begin
         rd(8'h10 + 8'(a), d);
         v = (a == 1) ? e_lo() : (a == 3) ? e_hi() : (a == 5) ? {4'h0, e_c()} : m[a];
         `CHK(d, v)
      end
      // Read data stands one cycle only, then falls back to zero
      @(posedge sys_clk);
      #1 `CHK(rd_data, 8'h00)
      rd(8'h20, d);
      `CHK(d, 8'h00)
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #(50 * 20000);
      fail_count++;
      close_out();
   end

   // -----------------------------------------
   // Tests
   // -----------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      srst <= 0;
      rd_all();
      `CHK({lo_n, hi_n, c_n}, 20'hF_FFFF)
      $display("test reset done");
      repeat (4) begin
         for (int a = 1; a < 6; a += 2) wr(8'h10 + 8'(a), 8'h00);
         for (int a = 0; a < 6; a++) wr(8'h10 + 8'(a), 8'($random(seed)));
         ext <= 16'($random(seed));
         c_ext <= 4'($random(seed));
         #1 `CHK({lo_o, lo_n, hi_o, hi_n}, {m[1], m[0], m[3], m[2]})
         `CHK({c_o, c_n}, {m[5][3:0], m[4][3:0]})
         rd_all();
      end
      $display("test gpio done");
      wr(8'h11, 8'hA5);
      warm <= 1;
      @(posedge sys_clk);
      warm <= 0;
      m[0] = 8'hFF;
      m[2] = 8'hFF;
      m[4] = 8'h0F;
      #1 `CHK({lo_n, hi_n, c_n}, 20'hF_FFFF)
      wr(8'h10, 8'h00);
      #1 `CHK(lo_o, 8'hA5)
      $display("test warm reset done");
      for (int md = 0; md < 4; md++) begin
         wr(8'h16, 8'(md));
         bus = (md == 1 || md == 2);
         #1 `CHK(bus_mode, bus)
         rd(8'h16, d);
         `CHK(d, {6'h00, m[6][1:0]})
         repeat (4) begin
            @(posedge sys_clk);
            {drive, ale, oe_n, wr_n} <= 4'($random(seed));
            ad_out <= 16'($random(seed));
            ext <= 16'($random(seed));
            c_ext <= 4'($random(seed));
            @(posedge sys_clk);
            #1 ce = e_c();
            `CHK({hi_i, lo_i}, {e_hi(), e_lo()})
            `CHK(c_i, ce)
            `CHK(c_n[2:0], bus ? 3'h0 : m[4][2:0])
            `CHK({c_n[3], cap}, {m[4][3], ce[3]})
            `CHK(ad_in, {e_hi(), e_lo()})
         end
      end
      $display("test bus modes done");
      close_out();
   end
endmodule // bmg_ports_tb
